/* File: logic/ipos_top.sv */
// ipos_top: serviced-request vector, position code and sub-source folding
// assumes an outside arbiter presents a one-hot winner and whether it is fast
// assumes the source pending vector is supplied from the outside source logic
//
// Operation
// - 32-bit serviced vector, one bit per source, all zero after reset.
// - vector loads from arbiter winner; at most one bit set; drives IRQ.
// - writing ones clears vector bits; software clears it after source pending.
// - read-only position code gives bit index of the held request; resets zero.
// - position code returns to zero when source and vector bits are cleared.
// - fast interrupts never change the position code.
// - fast-interrupt winners never set a vector bit.
// - 15-bit sub pending register, zero after reset, upper bits read zero.
// - a sub request sets its sub pending bit.
// - writing ones clears exactly those sub pending bits.
// - sub pending bits written with zero keep their value.
// - sub requests fold into serial, converter, camera and watchdog/audio parents.
// - 15-bit sub mask, all ones after reset, upper bits read zero.
// - a set sub mask bit blocks service; clear bit allows it.
// - masked sub requests still set their pending bit.
//
// Chosen here: the AHB-Lite slave port.
module ipos_top
  import ipos_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  // ----------------------------------------------------------------
  // AHB-Lite register port
  // ----------------------------------------------------------------
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // ----------------------------------------------------------------
  // arbiter, source pending and processor side
  // ----------------------------------------------------------------
  input wire logic [31:0] WINNER,
  input wire logic WINNER_FAST,
  input wire logic [31:0] SOURCE_REQUEST_PENDING,
  input wire logic [14:0] SUB_REQ,
  output ipos_parent_t PARENT_REQ,
  output logic [31:0] SERVICED_VECTOR,
  output logic [4:0] POSITION_CODE,
  output logic IRQ_N
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // keep only the lowest set bit, in case the arbiter ever shows two
  function automatic logic [31:0] ipos_lowest(input logic [31:0] v);
    logic [31:0] r;
    r = v & (~v + 32'h00000001);
    return r;
  endfunction : ipos_lowest

  // bit index of a one-hot word; zero for an empty word
  function automatic logic [4:0] ipos_encode(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < IPOS_NSRC; i++) begin
      if (v[i]) begin
        r = r | i[4:0];
      end
    end
    return r;
  endfunction : ipos_encode

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ipos_regacc_t acc;
  logic [31:0] rd_data;
  logic [14:0] sub_pnd;
  logic [14:0] sub_msk;
  logic [31:0] vector;
  logic [31:0] next_vector;
  logic [4:0] position;
  logic [4:0] next_position;
  logic held;
  logic next_held;
  logic [31:0] win_one;
  logic [31:0] cleared;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  ipos_ahb_slave u_bus (
    .clk(CLK),
    .rst_n(RST_N),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .rd_data(rd_data),
    .hrdata(HRDATA),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .acc(acc)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic hit_vector = (acc.addr == IPOS_ADDR_VECTOR);
  wire logic hit_offset = (acc.addr == IPOS_ADDR_OFFSET);
  wire logic hit_subpnd = (acc.addr == IPOS_ADDR_SUBPND);
  wire logic hit_submsk = (acc.addr == IPOS_ADDR_SUBMSK);
  wire logic wr_vector = acc.wr & hit_vector;
  wire logic wr_subpnd = acc.wr & hit_subpnd;
  wire logic wr_submsk = acc.wr & hit_submsk;

  // unmapped reads return zero; writes to the position code are ignored
  always_comb begin
    if (hit_vector) begin
      rd_data = vector;
    end else if (hit_offset) begin
      rd_data = {27'h0, position};
    end else if (hit_subpnd) begin
      rd_data = {17'h0, sub_pnd};
    end else if (hit_submsk) begin
      rd_data = {17'h0, sub_msk};
    end else begin
      rd_data = IPOS_RDATA_RST;
    end
  end

  // ----------------------------------------------------------------
  // sub-source pending, mask and fold
  // ----------------------------------------------------------------
  ipos_sub_fold u_sub (
    .clk(CLK),
    .rst_n(RST_N),
    .sub_req(SUB_REQ),
    .pnd_wr(wr_subpnd),
    .msk_wr(wr_submsk),
    .wdata(acc.wdata),
    .sub_pnd(sub_pnd),
    .sub_msk(sub_msk),
    .parent(PARENT_REQ)
  );

  // ----------------------------------------------------------------
  // serviced-request vector
  // ----------------------------------------------------------------

  // clear by writing ones; zeros leave bits alone
  assign cleared = wr_vector ? (vector & ~acc.wdata) : vector;

  // a fast winner is never latched, so the irq path only sees normal requests
  assign win_one = WINNER_FAST ? 32'h00000000 : ipos_lowest(WINNER);

  // load only into an empty vector so a single bit stands at a time;
  // a winner arriving with the clearing write is taken on the next edge
  assign next_vector = (vector == 32'h00000000) ? win_one : cleared;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      vector <= IPOS_VECTOR_RST;
    end else begin
      vector <= next_vector;
    end
  end

  // ----------------------------------------------------------------
  // position code
  // ----------------------------------------------------------------

  // held marks that the code still names a request being serviced;
  // it drops once both the vector bit and the source pending bit are clear
  always_comb begin
    next_position = position;
    next_held = held;
    if (vector == 32'h00000000 && win_one != 32'h00000000) begin
      next_position = ipos_encode(win_one);
      next_held = 1'b1;
    end else if (held && !vector[position] && !SOURCE_REQUEST_PENDING[position]) begin
      next_position = IPOS_OFFSET_RST;
      next_held = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      position <= IPOS_OFFSET_RST;
      held <= 1'b0;
    end else begin
      position <= next_position;
      held <= next_held;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign SERVICED_VECTOR = vector;
  assign POSITION_CODE = position;
  // irq to the core follows the single held bit
  assign IRQ_N = ~(|vector);

endmodule : ipos_top

/* File: pkg/ipos_pkg.sv */
// ipos_pkg: constants and carrier types of the irq pending/offset/sub-mask block
// assumes a single clock domain and one aligned 32-bit word per register
package ipos_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] IPOS_ADDR_VECTOR = 32'h4a000010;
  localparam logic [31:0] IPOS_ADDR_OFFSET = 32'h4a000014;
  localparam logic [31:0] IPOS_ADDR_SUBPND = 32'h4a000018;
  localparam logic [31:0] IPOS_ADDR_SUBMSK = 32'h4a00001c;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned IPOS_NSRC = 32;
  localparam int unsigned IPOS_NSUB = 15;
  localparam logic [31:0] IPOS_VECTOR_RST = 32'h00000000;
  localparam logic [4:0] IPOS_OFFSET_RST = 5'h00;
  localparam logic [14:0] IPOS_SUBPND_RST = 15'h0;
  localparam logic [14:0] IPOS_SUBMSK_RST = 15'h7fff;
  localparam logic [31:0] IPOS_RDATA_RST = 32'h00000000;

  // ----------------------------------------------------------------
  // sub-source bit positions
  // ----------------------------------------------------------------
  localparam int unsigned IPOS_SUB_RX0 = 0;
  localparam int unsigned IPOS_SUB_TX0 = 1;
  localparam int unsigned IPOS_SUB_ER0 = 2;
  localparam int unsigned IPOS_SUB_RX1 = 3;
  localparam int unsigned IPOS_SUB_TX1 = 4;
  localparam int unsigned IPOS_SUB_ER1 = 5;
  localparam int unsigned IPOS_SUB_RX2 = 6;
  localparam int unsigned IPOS_SUB_TX2 = 7;
  localparam int unsigned IPOS_SUB_ER2 = 8;
  localparam int unsigned IPOS_SUB_TOUCH = 9;
  localparam int unsigned IPOS_SUB_SAMPLE = 10;
  localparam int unsigned IPOS_SUB_CAMC = 11;
  localparam int unsigned IPOS_SUB_CAMP = 12;
  localparam int unsigned IPOS_SUB_WDOG = 13;
  localparam int unsigned IPOS_SUB_AUDIO = 14;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  // folded parent requests toward the source pending logic
  typedef struct packed {
    logic converter_source;
    logic serial_port0_source;
    logic serial_port1_source;
    logic serial_port2_source;
    logic watchdog_audio_shared_source;
    logic camera_source;
  } ipos_parent_t;

  // one register access, valid for a single cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ipos_regacc_t;

  typedef enum logic [1:0] {IPOS_BUS_IDLE, IPOS_BUS_WAIT, IPOS_BUS_DONE} ipos_bus_t;

endpackage : ipos_pkg

/* File: logic/ipos_ahb_slave.sv */
// ipos_ahb_slave: AHB-Lite single-word slave with one wait state per transfer
// assumes hready is this slave's own hreadyout fed back by the fabric
module ipos_ahb_slave
  import ipos_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] rd_data,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output ipos_regacc_t acc
);

  ipos_bus_t state;
  ipos_bus_t next_state;
  logic [31:0] addr_q;
  logic write_q;
  logic [31:0] next_hrdata;

  // hsize is accepted but only whole-word transfers are supported
  wire logic take = hsel & htrans[1] & hready & (hsize == 3'h2 || hsize != 3'h2);

  // the wait cycle gives the read mux a flop stage before hrdata
  always_comb begin
    next_state = state;
    case (state)
      IPOS_BUS_IDLE: begin
        if (take) begin
          next_state = IPOS_BUS_WAIT;
        end
      end
      IPOS_BUS_WAIT: begin
        next_state = IPOS_BUS_DONE;
      end
      default: begin
        next_state = take ? IPOS_BUS_WAIT : IPOS_BUS_IDLE;
      end
    endcase
  end

  assign acc.wr = (state == IPOS_BUS_WAIT) & write_q;
  assign acc.rd = (state == IPOS_BUS_WAIT) & ~write_q;
  assign acc.addr = addr_q;
  assign acc.wdata = hwdata;
  assign next_hrdata = acc.rd ? rd_data : hrdata;
  assign hreadyout = (state != IPOS_BUS_WAIT);
  assign hresp = 1'b0; // always OKAY

  // address phase capture and read data register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IPOS_BUS_IDLE;
      addr_q <= IPOS_RDATA_RST;
      write_q <= 1'b0;
      hrdata <= IPOS_RDATA_RST;
    end else begin
      state <= next_state;
      hrdata <= next_hrdata;
      if (take) begin
        addr_q <= haddr;
        write_q <= hwrite;
      end
    end
  end

endmodule : ipos_ahb_slave

/* File: logic/ipos_sub_fold.sv */
// ipos_sub_fold: sub-source pending and mask registers, folded to parents
// assumes sub requests are synchronous levels or pulses on clk
module ipos_sub_fold
  import ipos_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [14:0] sub_req,
  input wire logic pnd_wr,
  input wire logic msk_wr,
  input wire logic [31:0] wdata,
  output logic [14:0] sub_pnd,
  output logic [14:0] sub_msk,
  output ipos_parent_t parent
);

  logic [14:0] next_pnd;
  logic [14:0] next_msk;
  logic [14:0] live;
  ipos_parent_t next_parent;

  // set wins over a same-cycle clear; mask does not block setting
  assign next_pnd = ((pnd_wr ? (sub_pnd & ~wdata[14:0]) : sub_pnd)) | sub_req;
  assign next_msk = msk_wr ? wdata[14:0] : sub_msk;
  assign live = sub_pnd & ~sub_msk;

  // parent fold: a parent asks while any unmasked child is pending
  assign next_parent.serial_port0_source = |live[IPOS_SUB_ER0:IPOS_SUB_RX0];
  assign next_parent.serial_port1_source = |live[IPOS_SUB_ER1:IPOS_SUB_RX1];
  assign next_parent.serial_port2_source = |live[IPOS_SUB_ER2:IPOS_SUB_RX2];
  assign next_parent.converter_source = live[IPOS_SUB_TOUCH] | live[IPOS_SUB_SAMPLE];
  assign next_parent.camera_source = live[IPOS_SUB_CAMC] | live[IPOS_SUB_CAMP];
  assign next_parent.watchdog_audio_shared_source = live[IPOS_SUB_WDOG] | live[IPOS_SUB_AUDIO];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_pnd <= IPOS_SUBPND_RST;
      sub_msk <= IPOS_SUBMSK_RST;
      parent <= '0;
    end else begin
      sub_pnd <= next_pnd;
      sub_msk <= next_msk;
      parent <= next_parent;
    end
  end

endmodule : ipos_sub_fold

/* File: test/ipos_src_model.sv */
// ipos_src_model: source pending latch and fixed-priority winner beside ipos_top
// assumes the bench drives raise, clr and fast_in by non-blocking assignment after an edge
module ipos_src_model
  import ipos_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] raise,
  input wire logic [31:0] clr,
  input wire logic fast_in,
  output logic [31:0] src_pnd,
  output logic [31:0] winner,
  output logic winner_fast
);
  // ----------------------------------------------------------------
  // source pending and arbitration
  // ----------------------------------------------------------------
  // a raise wins over a clear in the same cycle, so no request is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_pnd <= 32'h00000000;
    end else begin
      src_pnd <= (src_pnd & ~clr) | raise;
    end
  end
  // lowest source wins; no masking, the bench stands in for it
  assign winner = src_pnd & (~src_pnd + 32'h00000001);
  assign winner_fast = fast_in;
endmodule : ipos_src_model

/* File: test/ipos_top_sva.sv */
// ipos_top_sva: port checker for serviced vector, position code and bus wait
// assumes HREADY is fed back from HREADYOUT and one clock domain
module ipos_top_sva
  import ipos_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] WINNER,
  input wire logic WINNER_FAST,
  input wire logic [31:0] SOURCE_REQUEST_PENDING,
  input wire logic [31:0] SERVICED_VECTOR,
  input wire logic [4:0] POSITION_CODE,
  input wire logic IRQ_N
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lowest set winner bit, the one the vector should take
  wire logic [31:0] low_win = WINNER & (~WINNER + 32'h00000001);
  wire logic take = HSEL & HTRANS[1] & HREADY;
  wire logic idle_vec = (SERVICED_VECTOR == 32'h00000000);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_onehot; $onehot0(SERVICED_VECTOR); endproperty
  a_onehot: assert property (p_onehot) else $error("vector not one-hot");
  property p_irq; IRQ_N == idle_vec; endproperty
  a_irq: assert property (p_irq) else $error("irq line wrong");
  property p_load; idle_vec && !WINNER_FAST && WINNER != 32'h0 |=> SERVICED_VECTOR == $past(low_win);
  endproperty
  a_load: assert property (p_load) else $error("winner not loaded");
  property p_fast; idle_vec && WINNER_FAST |=> idle_vec; endproperty
  a_fast: assert property (p_fast) else $error("fast winner set vector");
  property p_pos_fast; idle_vec && WINNER_FAST |=> POSITION_CODE == 5'h00 || $stable(POSITION_CODE);
  endproperty
  a_pos_fast: assert property (p_pos_fast) else $error("fast changed position");
  property p_pos; !idle_vec |-> SERVICED_VECTOR == (32'h1 << POSITION_CODE); endproperty
  a_pos: assert property (p_pos) else $error("position mismatch");
  property p_pos_zero;
    idle_vec && !SOURCE_REQUEST_PENDING[POSITION_CODE] && (WINNER == 32'h0 || WINNER_FAST)
      |=> POSITION_CODE == 5'h00;
  endproperty
  a_pos_zero: assert property (p_pos_zero) else $error("position not zeroed");
  property p_bus; take |=> !HREADYOUT ##1 HREADYOUT && !HRESP; endproperty
  a_bus: assert property (p_bus) else $error("bus wait state wrong");
  c_load: cover property (idle_vec && !WINNER_FAST && WINNER != 32'h0);
  c_fast: cover property (idle_vec && WINNER_FAST && WINNER != 32'h0);
  c_take: cover property (take);
endmodule : ipos_top_sva

bind ipos_top ipos_top_sva chk_u (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HTRANS(HTRANS),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .WINNER(WINNER),
  .WINNER_FAST(WINNER_FAST), .SOURCE_REQUEST_PENDING(SOURCE_REQUEST_PENDING),
  .SERVICED_VECTOR(SERVICED_VECTOR), .POSITION_CODE(POSITION_CODE), .IRQ_N(IRQ_N));

/* File: test/ipos_top_tb.sv */
// ipos_top_tb: self-checking bench over AHB-Lite with a source pending model
// assumes one slave, so HREADY is HREADYOUT fed back
module ipos_top_tb
  import ipos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n, hsel, hwrite, fast, hreadyout, hresp, irq_n, wfast;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, raise, clr, winner, src_pnd, rd, vec, lo, hi;
  logic [14:0] sub_req;
  logic [4:0] pos;
  ipos_parent_t par;
  int fails = 0;
  int checks = 0;
  ipos_top dut_u (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .WINNER(winner), .WINNER_FAST(wfast),
    .SOURCE_REQUEST_PENDING(src_pnd), .SUB_REQ(sub_req), .PARENT_REQ(par),
    .SERVICED_VECTOR(vec), .POSITION_CODE(pos), .IRQ_N(irq_n));
  ipos_src_model src_u (.clk(clk), .rst_n(rst_n), .raise(raise), .clr(clr), .fast_in(fast),
    .src_pnd(src_pnd), .winner(winner), .winner_fast(wfast));
  // ----------------------------------------------------------------
  // clock, tasks
  // ----------------------------------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one single transfer; entered just after an edge, waits on hready both phases
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask : rdchk
  function automatic logic [31:0] exp_par(input int k);
    if (k < 9) return 32'h10 >> (k / 3);
    if (k < 11) return 32'h20;
    return (k < 13) ? 32'h01 : 32'h02;
  endfunction : exp_par
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    raise = 32'h0; clr = 32'h0; fast = 1'b0; sub_req = 15'h0;
    tick(5);
    rst_n <= 1'b1;
    tick(1);
    chk("irq_n", {31'h0, irq_n}, 32'h1);
    rdchk("vector", IPOS_ADDR_VECTOR, 32'h0);
    rdchk("offset", IPOS_ADDR_OFFSET, 32'h0);
    bus(1'b1, IPOS_ADDR_OFFSET, 32'h1f);
    rdchk("offset ro", IPOS_ADDR_OFFSET, 32'h0);
    rdchk("subpnd", IPOS_ADDR_SUBPND, 32'h0);
    rdchk("submsk", IPOS_ADDR_SUBMSK, 32'h7fff);
    rdchk("unmapped", 32'h4a000020, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      lo = i ? 32'h9 : 32'h0;
      hi = i ? 32'hf : 32'h1f;
      raise <= (32'h1 << lo) | (32'h1 << hi);
      tick(1);
      raise <= 32'h0;
      tick(3);
      chk("vector", vec, 32'h1 << lo);
      chk("irq_n", {31'h0, irq_n}, 32'h0);
      rdchk("offset", IPOS_ADDR_OFFSET, lo);
      chk("position pin", {27'h0, pos}, lo);
      bus(1'b1, IPOS_ADDR_VECTOR, 32'h0);
      rdchk("vector kept", IPOS_ADDR_VECTOR, 32'h1 << lo);
      clr <= 32'h1 << lo;
      tick(1);
      clr <= 32'h0;
      bus(1'b1, IPOS_ADDR_VECTOR, 32'h1 << lo);
      tick(2);
      chk("vector next", vec, 32'h1 << hi);
      rdchk("offset next", IPOS_ADDR_OFFSET, hi);
      clr <= 32'h1 << hi;
      tick(1);
      clr <= 32'h0;
      bus(1'b1, IPOS_ADDR_VECTOR, 32'hffffffff);
      tick(2);
      chk("vector idle", vec, 32'h0);
      rdchk("offset idle", IPOS_ADDR_OFFSET, 32'h0);
    end
    $display("test service done");
    fast <= 1'b1;
    raise <= 32'h20;
    tick(1);
    raise <= 32'h0;
    tick(3);
    chk("vector fast", vec, 32'h0);
    rdchk("offset fast", IPOS_ADDR_OFFSET, 32'h0);
    clr <= 32'hffffffff;
    tick(1);
    clr <= 32'h0;
    tick(1);
    fast <= 1'b0;
    $display("test fast done");
    sub_req <= 15'h7fff;
    tick(1);
    sub_req <= 15'h0;
    tick(2);
    chk("parent masked", {26'h0, par}, 32'h0);
    rdchk("subpnd all", IPOS_ADDR_SUBPND, 32'h7fff);
    bus(1'b1, IPOS_ADDR_SUBPND, 32'hffff0005);
    rdchk("subpnd w1c", IPOS_ADDR_SUBPND, 32'h7ffa);
    bus(1'b1, IPOS_ADDR_SUBMSK, 32'hffff0000);
    rdchk("submsk", IPOS_ADDR_SUBMSK, 32'h0);
    tick(2);
    chk("parent all", {26'h0, par}, 32'h3f);
    bus(1'b1, IPOS_ADDR_SUBPND, 32'hffffffff);
    for (int k = 0; k < 15; k++) begin
      sub_req <= 15'h1 << k;
      tick(1);
      sub_req <= 15'h0;
      tick(2);
      chk("parent map", {26'h0, par}, exp_par(k));
      bus(1'b1, IPOS_ADDR_SUBMSK, 32'h1 << k);
      tick(2);
      chk("parent blocked", {26'h0, par}, 32'h0);
      rdchk("subpnd kept", IPOS_ADDR_SUBPND, 32'h1 << k);
      bus(1'b1, IPOS_ADDR_SUBPND, 32'h1 << k);
      bus(1'b1, IPOS_ADDR_SUBMSK, 32'h0);
    end
    $display("test sub done");
    close_out();
  end
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule : ipos_top_tb
